// [src/bsr_pkg.sv]
// Purpose: Shared constants and carrier types for the bidirectional shift register
// Assumes: One reference clock; all pin inputs are asynchronous to it
// Notes: Mode codes are the select pins read as {high, low}
package bsr_pkg;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int BSR_WIDTH = 8;
  localparam int BSR_FIFO_DEPTH = 8;
  localparam int BSR_SYNC_STAGES = 2;
  localparam logic [BSR_WIDTH-1:0] BSR_DATA_RST = 8'h00;
  localparam logic [3:0] BSR_FILL_RST = 4'h0;
  localparam logic [3:0] BSR_FILL_FULL = 4'h8;
  localparam logic [3:0] BSR_FILL_STEP = 4'h1;
  localparam int BSR_LSB = 0;
  localparam int BSR_MSB = BSR_WIDTH - 1;

  // ----------------------------------------------------------------
  // Operating modes, decoded from {mode_select_high, mode_select_low}
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BSR_MODE_LOAD = 2'b00,
    BSR_MODE_UP = 2'b01,
    BSR_MODE_DOWN = 2'b10,
    BSR_MODE_HOLD = 2'b11
  } bsr_mode_e;

  // Pin group sampled together through the synchroniser
  typedef struct packed {
    logic sel_high;
    logic sel_low;
    logic ser_high;
    logic ser_low;
    logic [BSR_WIDTH-1:0] par;
  } bsr_pins_s;

  // One record per accepted clock edge, pushed into the FIFO if it has room
  typedef struct packed {
    bsr_mode_e mode;
    logic [BSR_WIDTH-1:0] value;
  } bsr_snap_s;

  localparam int BSR_PINS_W = $bits(bsr_pins_s);
  localparam int BSR_SNAP_W = $bits(bsr_snap_s);

endpackage : bsr_pkg

// [src/bsr_fifo.sv]
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes: Read data leave from an output register; DEPTH words sit behind it
`timescale 1ns/1ps
module bsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_MAX = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW-1:0] PTR_ZERO = '0;
  localparam logic [AW-1:0] PTR_ONE = AW'(1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic out_valid_r;
  logic [WIDTH-1:0] out_data_r;

  // ----------------------------------------------------------------
  // Handshake decode
  // ----------------------------------------------------------------
  wire push = in_valid_i && in_ready_o;
  wire mem_empty = (count_r == '0);
  // Output stage refills whenever it is empty or being drained
  wire pop = !mem_empty && (!out_valid_r || out_ready_i);
  wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  wire [AW-1:0] wr_ptr_nxt = (wr_ptr_r == PTR_LAST) ? PTR_ZERO : wr_ptr_r + PTR_ONE;
  wire [AW-1:0] rd_ptr_nxt = (rd_ptr_r == PTR_LAST) ? PTR_ZERO : rd_ptr_r + PTR_ONE;

  assign in_ready_o = (count_r != CNT_MAX);
  assign out_valid_o = out_valid_r;
  assign out_data_o = out_data_r;

  // Storage array, no reset needed on data
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_nxt;
      if (pop) rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem_r[rd_ptr_r];
    end else if (out_ready_i) begin
      out_valid_r <= 1'b0;
    end
  end

endmodule : bsr_fifo

// [src/bsr_shift_reg.sv]
// Purpose: Eight-bit bidirectional shift register with load, shift up, shift down and hold
// Assumes: shift_clock and all data/select pins are asynchronous to REF_CLK_I and
//          each level of shift_clock lasts at least two reference cycles
// Notes: Every accepted edge also posts a {mode, value} record into a FIFO, which drops it when full
`timescale 1ns/1ps
module bsr_shift_reg
  import bsr_pkg::*;
#(
  parameter int WIDTH = bsr_pkg::BSR_WIDTH,
  parameter int FIFO_DEPTH = bsr_pkg::BSR_FIFO_DEPTH
) (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic SHIFT_CLOCK_I,
  input wire logic MODE_SELECT_LOW_I,
  input wire logic MODE_SELECT_HIGH_I,
  input wire logic SERIAL_IN_LOW_END_I,
  input wire logic SERIAL_IN_HIGH_END_I,
  input wire logic [bsr_pkg::BSR_WIDTH-1:0] PARALLEL_IN_I,
  output logic [bsr_pkg::BSR_WIDTH-1:0] REGISTER_OUT_O,
  output logic REGISTER_VALID_O,
  output logic SNAP_IN_READY_O,
  output logic SNAP_VALID_O,
  input wire logic SNAP_READY_I,
  output bsr_pkg::bsr_snap_s SNAP_O,
  output logic SNAP_LOST_O,
  input wire logic SNAP_LOST_CLR_I
);
  import bsr_pkg::*;

  // ----------------------------------------------------------------
  // Next-value function, called only by the datapath
  // ----------------------------------------------------------------
  function automatic logic [BSR_WIDTH-1:0] next_value(
    input bsr_mode_e mode,
    input logic [BSR_WIDTH-1:0] cur,
    input bsr_pins_s pins
  );
    logic [BSR_WIDTH-1:0] res;
    res = cur;
    unique case (mode)
      BSR_MODE_LOAD: res = pins.par;
      BSR_MODE_UP: res = {cur[BSR_MSB-1:BSR_LSB], pins.ser_low};
      BSR_MODE_DOWN: res = {pins.ser_high, cur[BSR_MSB:BSR_LSB+1]};
      BSR_MODE_HOLD: res = cur;
    endcase
    return res;
  endfunction : next_value

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  bsr_pins_s pins_raw;
  bsr_pins_s pins_meta_r;
  bsr_pins_s pins_s_r;
  logic clk_meta_r;
  logic clk_s_r;
  logic clk_d_r;

  assign pins_raw.sel_high = MODE_SELECT_HIGH_I;
  assign pins_raw.sel_low = MODE_SELECT_LOW_I;
  assign pins_raw.ser_high = SERIAL_IN_HIGH_END_I;
  assign pins_raw.ser_low = SERIAL_IN_LOW_END_I;
  assign pins_raw.par = PARALLEL_IN_I;

  // Data and clock take the same two stages so they stay aligned
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pins_meta_r <= '0;
      pins_s_r <= '0;
      clk_meta_r <= 1'b0;
      clk_s_r <= 1'b0;
    end else begin
      pins_meta_r <= pins_raw;
      pins_s_r <= pins_meta_r;
      clk_meta_r <= SHIFT_CLOCK_I;
      clk_s_r <= clk_meta_r;
    end
  end

  // Edge detector looks only at the second stage
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s_r;
    end
  end

  // ----------------------------------------------------------------
  // Edge and mode decode
  // ----------------------------------------------------------------
  wire clk_rise = clk_s_r && !clk_d_r;
  wire bsr_mode_e mode = bsr_mode_e'({pins_s_r.sel_high, pins_s_r.sel_low});
  wire is_load = (mode == BSR_MODE_LOAD);
  wire is_shift = (mode == BSR_MODE_UP) || (mode == BSR_MODE_DOWN);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [BSR_WIDTH-1:0] data_r;
  logic [BSR_WIDTH-1:0] data_nxt;
  logic [3:0] fill_r;
  logic [3:0] fill_nxt;
  logic valid_r;
  logic valid_nxt;

  // Update only on the detected rising edge, otherwise keep
  assign data_nxt = clk_rise ? next_value(mode, data_r, pins_s_r) : data_r;

  // Contents are reset only so outputs are defined; meaning comes from valid_r
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      data_r <= BSR_DATA_RST;
    end else begin
      data_r <= data_nxt;
    end
  end

  // Fill tracking: a load or eight shifts make every bit known
  assign fill_nxt = (clk_rise && is_load) ? BSR_FILL_FULL :
                    (clk_rise && is_shift && fill_r != BSR_FILL_FULL) ? fill_r + BSR_FILL_STEP :
                    fill_r;
  assign valid_nxt = (fill_nxt == BSR_FILL_FULL);

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fill_r <= BSR_FILL_RST;
      valid_r <= 1'b0;
    end else begin
      fill_r <= fill_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign REGISTER_OUT_O = data_r;
  assign REGISTER_VALID_O = valid_r;

  // ----------------------------------------------------------------
  // Snapshot FIFO
  // ----------------------------------------------------------------
  bsr_snap_s snap_in;
  bsr_snap_s snap_out;
  logic fifo_in_ready;
  logic lost_r;

  assign snap_in.mode = mode;
  assign snap_in.value = data_nxt;

  bsr_fifo #(
    .WIDTH(BSR_SNAP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(REF_CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(clk_rise),
    .in_ready_o(fifo_in_ready),
    .in_data_i(snap_in),
    .out_valid_o(SNAP_VALID_O),
    .out_ready_i(SNAP_READY_I),
    .out_data_o(snap_out)
  );

  assign SNAP_O = snap_out;
  assign SNAP_IN_READY_O = fifo_in_ready;

  // Register never stalls, so a full FIFO drops the record; set beats clear
  wire lost_set = clk_rise && !fifo_in_ready;

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lost_r <= 1'b0;
    end else if (lost_set) begin
      lost_r <= 1'b1;
    end else if (SNAP_LOST_CLR_I) begin
      lost_r <= 1'b0;
    end
  end

  assign SNAP_LOST_O = lost_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Helper: load seen and shifts counted apart, so the valid flag is not checked against itself
  logic chk_loaded_r;
  logic [3:0] chk_shifts_r;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      chk_loaded_r <= 1'b0;
      chk_shifts_r <= BSR_FILL_RST;
    end else if (clk_rise) begin
      if (is_load) begin
        chk_loaded_r <= 1'b1;
      end
      if (is_shift && chk_shifts_r != BSR_FILL_FULL) begin
        chk_shifts_r <= chk_shifts_r + BSR_FILL_STEP;
      end
    end
  end

  port_follow_a: assert property (
    clk_rise |=> REGISTER_OUT_O == $past(data_nxt))
    else $error("Outputs do not show the stored bits");

  // A record into an empty FIFO leaves two edges later with the new contents and mode
  snap_follow_a: assert property (
    (clk_rise && !SNAP_VALID_O && u_fifo.mem_empty)
      |=> ##1 SNAP_VALID_O && (SNAP_O.value == $past(REGISTER_OUT_O)) && (SNAP_O.mode == $past(mode, 2)))
    else $error("Record does not match the accepted edge");

  edge_only_a: assert property (
    !(clk_s_r && !clk_d_r) |=> $stable(REGISTER_OUT_O))
    else $error("Stored bits changed without a shift clock rise");

  one_mode_a: assert property (
    clk_rise |-> $onehot({is_load, mode == BSR_MODE_UP, mode == BSR_MODE_DOWN, mode == BSR_MODE_HOLD}))
    else $error("Mode decode not one of four");

  par_load_a: assert property (
    (clk_rise && !pins_s_r.sel_high && !pins_s_r.sel_low) |=> REGISTER_OUT_O == $past(pins_s_r.par))
    else $error("Parallel load wrong");

  shift_up_a: assert property (
    (clk_rise && !pins_s_r.sel_high && pins_s_r.sel_low)
      |=> REGISTER_OUT_O == {$past(REGISTER_OUT_O[BSR_MSB-1:BSR_LSB]), $past(pins_s_r.ser_low)})
    else $error("Shift toward high end wrong");

  shift_down_a: assert property (
    (clk_rise && pins_s_r.sel_high && !pins_s_r.sel_low)
      |=> REGISTER_OUT_O == {$past(pins_s_r.ser_high), $past(REGISTER_OUT_O[BSR_MSB:BSR_LSB+1])})
    else $error("Shift toward low end wrong");

  hold_keep_a: assert property (
    (pins_s_r.sel_high && pins_s_r.sel_low)[*2] |-> $stable(REGISTER_OUT_O))
    else $error("Hold mode changed the stored bits");

  fill_valid_a: assert property (
    ##1 REGISTER_VALID_O == (chk_loaded_r || chk_shifts_r == BSR_FILL_FULL))
    else $error("Valid flag disagrees with load or eight shifts");

  // ----------------------------------------------------------------
  // Edge, valid-flag and record stream checks
  // ----------------------------------------------------------------

  // A rise in hold mode must leave the contents alone
  hold_edge_a: assert property (
    (clk_rise && mode == BSR_MODE_HOLD) |=> $stable(REGISTER_OUT_O))
    else $error("Hold edge changed the stored bits");

  // A dropped record must not stall the register itself
  drop_load_a: assert property (
    (clk_rise && is_load && !SNAP_IN_READY_O) |=> REGISTER_OUT_O == $past(pins_s_r.par))
    else $error("Load lost while the FIFO was full");

  // Loading makes every bit known at once
  load_valid_a: assert property (
    (clk_rise && is_load) |=> REGISTER_VALID_O)
    else $error("Load did not mark contents valid");

  // Only reset takes the valid flag down again
  valid_keep_a: assert property (
    REGISTER_VALID_O |=> REGISTER_VALID_O)
    else $error("Valid flag dropped without reset");

  // Contents become known only through an accepted load or shift
  valid_rise_a: assert property (
    $rose(REGISTER_VALID_O) |-> $past(clk_rise && (is_load || is_shift)))
    else $error("Valid flag rose without a load or shift");

  // A loss in the cycle of a clear keeps the flag set
  lost_wins_a: assert property (
    lost_set |=> SNAP_LOST_O)
    else $error("Lost flag missed a dropped record");

  // A clear with no new loss empties the flag next cycle
  lost_clear_a: assert property (
    (SNAP_LOST_CLR_I && !lost_set) |=> !SNAP_LOST_O)
    else $error("Lost flag ignored its clear");

  // A record waiting for the consumer stands unchanged
  stall_hold_a: assert property (
    (SNAP_VALID_O && !SNAP_READY_I) |=> SNAP_VALID_O && $stable(SNAP_O))
    else $error("Record changed while stalled");

  // A full store implies the output stage is occupied as well
  full_occupied_a: assert property (
    !SNAP_IN_READY_O |-> SNAP_VALID_O)
    else $error("FIFO full with an empty output stage");

  // No record appears without an accepted edge behind it
  idle_quiet_a: assert property (
    (!SNAP_VALID_O && u_fifo.mem_empty && !clk_rise) |=> !SNAP_VALID_O)
    else $error("Record appeared without a shift clock rise");

endmodule : bsr_shift_reg

// [sim/bsr_pin_drv.sv]
// Purpose: Stand-in for the synchronous logic that drives the register pins
// Assumes: One transfer at a time, called from the bench at a reference edge
// Notes: Pins are inverted once their hold time is over, so stale values cannot pass
`timescale 1ns/1ps
module bsr_pin_drv (
  input wire logic clk_i,
  output logic sck_o,
  output logic sel_lo_o,
  output logic sel_hi_o,
  output logic ser_lo_o,
  output logic ser_hi_o,
  output logic [bsr_pkg::BSR_WIDTH-1:0] par_o
);
  import bsr_pkg::*;

  // Idle levels from time zero, shift clock low at reset release
  initial begin
    {sck_o, sel_hi_o, sel_lo_o, ser_hi_o, ser_lo_o, par_o} = '0;
  end

  // ----------------------------------------------------------------
  // One shift clock pulse: two cycles setup, three high, two low
  // ----------------------------------------------------------------
  task automatic pulse(input bsr_mode_e mode, input logic [BSR_WIDTH-1:0] par, input logic sl, input logic sh);
    @(posedge clk_i);
    {sel_hi_o, sel_lo_o} <= mode;
    {ser_hi_o, ser_lo_o, par_o} <= {sh, sl, par};
    repeat (2) @(posedge clk_i);
    sck_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Hold is over: scramble everything so a late sample shows up
    {sel_hi_o, sel_lo_o, ser_hi_o, ser_lo_o, par_o} <= ~{mode, sh, sl, par};
    sck_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : pulse
endmodule : bsr_pin_drv

// [sim/bidir_shift_register_8bit_tb.sv]
// Purpose: Self-checking bench for the bidirectional shift register
// Assumes: Random data from a fixed seed; the pin driver keeps setup and hold
// Notes: Expected contents come from a bench function, records from a queue
`timescale 1ns/1ps
module bidir_shift_register_8bit_tb;
  import bsr_pkg::*;

  logic ref_clk;
  logic rst_n = 1'b0;
  logic snap_ready = 1'b0;
  logic lost_clr = 1'b0;
  logic hold_off = 1'b0;
  logic sck, sel_lo, sel_hi, ser_lo, ser_hi;
  logic [BSR_WIDTH-1:0] par, reg_out, exp_v;
  logic reg_valid, snap_in_ready, snap_valid, snap_lost;
  bsr_snap_s snap;
  bsr_snap_s q[$];
  int seed;
  int miscompares = 0;
  int n_tests = 0;

  // ----------------------------------------------------------------
  // Clock, design and pin driver
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  bsr_shift_reg #(.WIDTH(BSR_WIDTH), .FIFO_DEPTH(BSR_FIFO_DEPTH)) u_dut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n),
    .SHIFT_CLOCK_I(sck), .MODE_SELECT_LOW_I(sel_lo), .MODE_SELECT_HIGH_I(sel_hi), .SERIAL_IN_LOW_END_I(ser_lo),
    .SERIAL_IN_HIGH_END_I(ser_hi), .PARALLEL_IN_I(par), .REGISTER_OUT_O(reg_out), .REGISTER_VALID_O(reg_valid),
    .SNAP_IN_READY_O(snap_in_ready), .SNAP_VALID_O(snap_valid), .SNAP_READY_I(snap_ready), .SNAP_O(snap),
    .SNAP_LOST_O(snap_lost), .SNAP_LOST_CLR_I(lost_clr));

  bsr_pin_drv u_drv (.clk_i(ref_clk), .sck_o(sck), .sel_lo_o(sel_lo), .sel_hi_o(sel_hi), .ser_lo_o(ser_lo),
    .ser_hi_o(ser_hi), .par_o(par));

  // ----------------------------------------------------------------
  // Expectation, comparison and verdict
  // ----------------------------------------------------------------
  function automatic logic [BSR_WIDTH-1:0] nxt(input bsr_mode_e m, input logic [7:0] cur, input logic [7:0] p,
                                               input logic sl, input logic sh);
    case (m)
      BSR_MODE_LOAD: nxt = p;
      BSR_MODE_UP: nxt = {cur[6:0], sl};
      BSR_MODE_DOWN: nxt = {sh, cur[7:1]};
      default: nxt = cur;
    endcase
  endfunction : nxt

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // One accepted edge; a record is queued only if the FIFO can keep it
  task automatic op(input bsr_mode_e m, input logic [7:0] p, input logic sl, input logic sh, input bit keep);
    exp_v = nxt(m, exp_v, p, sl, sh);
    if (keep) q.push_back({m, exp_v});
    u_drv.pulse(m, p, sl, sh);
    check(reg_out, exp_v);
  endtask : op

  // Bounded wait for every queued record to be taken
  task automatic drain();
    for (int k = 0; k < 60 && q.size() > 0; k++) @(posedge ref_clk);
    check(q.size() == 0, 1'b1);
  endtask : drain

  // Consumer with random stalls; a take with nothing queued expects x
  always @(posedge ref_clk) begin
    if (snap_valid && snap_ready) begin
      check(snap, (q.size() > 0) ? q.pop_front() : 'x);
    end
    snap_ready <= hold_off ? 1'b0 : 1'($random(seed));
  end

  // Watchdog, far beyond the roughly 750 cycles of the sequence
  initial begin
    repeat (8000) @(posedge ref_clk);
    miscompares++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h2421;
    exp_v = BSR_DATA_RST;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    check(reg_out, BSR_DATA_RST);
    // Seven shifts leave contents unknown, holds do not count
    for (int i = 0; i < 8; i++) begin
      op(BSR_MODE_UP, 8'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'b1);
      op(BSR_MODE_HOLD, 8'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'b1);
      check(reg_valid, i == 7);
    end
    // End bits against opposite serial levels
    op(BSR_MODE_LOAD, 8'h81, 1'b1, 1'b1, 1'b1);
    op(BSR_MODE_UP, 8'h00, 1'b1, 1'b0, 1'b1);
    op(BSR_MODE_DOWN, 8'hFF, 1'b1, 1'b0, 1'b1);
    repeat (60) op(bsr_mode_e'(2'($random(seed))), 8'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'b1);
    drain();
    // Fill until the tenth record is refused, then clear and drain
    hold_off <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) op(BSR_MODE_LOAD, 8'($random(seed)), 1'b0, 1'b0, i < 9);
    check({snap_lost, snap_in_ready}, 2'b10);
    lost_clr <= 1'b1;
    @(posedge ref_clk);
    lost_clr <= 1'b0;
    @(posedge ref_clk);
    check(snap_lost, 1'b0);
    hold_off <= 1'b0;
    drain();
    // Reset in mid-run, then a fresh load
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({reg_valid, reg_out}, 9'h000);
    rst_n <= 1'b1;
    exp_v = BSR_DATA_RST;
    op(BSR_MODE_LOAD, 8'h5A, 1'b1, 1'b1, 1'b1);
    check(reg_valid, 1'b1);
    drain();
    summarize();
  end
endmodule : bidir_shift_register_8bit_tb
